// *** include/nfc_consts.svh ***
/*
 * Timing counts, opcodes and address layout of the flash command host.
 * Assumes a single system clock whose rate is given below in MHz.
 */
`ifndef NFC_CONSTS_SVH
`define NFC_CONSTS_SVH

// ============================================================
// Clock and timing
`define NFC_CLK_MHZ 125
`define NFC_NS2CYC(ns) (((ns) * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_T_WP_NS 25
`define NFC_T_WH_NS 15
`define NFC_T_REA_NS 30
`define NFC_T_REH_NS 15
`define NFC_T_WB_NS 100
`define NFC_SYNC_LAT 2

// ============================================================
// Opcodes
`define NFC_OPC_READ_LO 8'h00
`define NFC_OPC_READ_HI 8'h01
`define NFC_OPC_READ_SPARE 8'h50
`define NFC_OPC_READ_ID 8'h90
`define NFC_OPC_RESET 8'hff
`define NFC_OPC_PROG 8'h80
`define NFC_OPC_CONF_TRUE 8'h10
`define NFC_OPC_CONF_DUMMY 8'h11
`define NFC_OPC_COPY_SRC2 8'h03
`define NFC_OPC_COPY_DST 8'h8a
`define NFC_OPC_ERASE 8'h60
`define NFC_OPC_ERASE_CONF 8'hd0
`define NFC_OPC_STATUS 8'h70
`define NFC_OPC_STATUS_MULTI 8'h71

// ============================================================
// Address layout
`define NFC_PAGE_BYTES 528
`define NFC_ADDR_BITS 27
`define NFC_ROW_BITS 18
`define NFC_LEN_BITS 10
`define NFC_ADDR_CYC_PAGE 2'd3
`define NFC_ADDR_CYC_BLOCK 2'd2
`define NFC_GROUP_BIT 7

`endif

// *** include/nfc_cyc_if.sv ***
/*
 * Request/answer path between the sequencer and the strobe engine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface nfc_cyc_if;
	import nfc_pkg::*;
	logic req;
	nfc_kind_e kind;
	logic [7:0] wbyte;
	logic done;
	logic [7:0] rbyte;
	modport seq (output req, output kind, output wbyte,
		input done, input rbyte);
	modport eng (input req, input kind, input wbyte,
		output done, output rbyte);
endinterface : nfc_cyc_if

// *** include/nfc_pkg.sv ***
/*
 * Types shared by the flash command host modules.
 * Assumes nothing beyond the constants header.
 */
package nfc_pkg;

	// ============================================================
	// Operations requested by the user side
	typedef enum logic [3:0] {
		NFC_OP_READ_LO, NFC_OP_READ_HI, NFC_OP_READ_SPARE, NFC_OP_READ_ID,
		NFC_OP_RESET, NFC_OP_PROG, NFC_OP_PROG_DUMMY, NFC_OP_COPY,
		NFC_OP_COPY_DUMMY, NFC_OP_ERASE, NFC_OP_ERASE_ADD, NFC_OP_STATUS,
		NFC_OP_STATUS_MULTI
	} nfc_op_e;

	// ============================================================
	// Bus cycle kinds
	typedef enum logic [1:0] {
		NFC_K_CMD = 2'h0, NFC_K_ADDR = 2'h1, NFC_K_WDATA = 2'h2,
		NFC_K_RDATA = 2'h3
	} nfc_kind_e;

	// ============================================================
	// Sequencer states, Gray along the usual path
	typedef enum logic [2:0] {
		NFC_S_IDLE = 3'h0, NFC_S_CMD = 3'h1, NFC_S_ADDR = 3'h3,
		NFC_S_WDATA = 3'h2, NFC_S_CONF = 3'h6, NFC_S_WAITB = 3'h7,
		NFC_S_READ = 3'h5, NFC_S_FIN = 3'h4
	} nfc_st_e;

	// Strobe phases
	typedef enum logic [1:0] {
		NFC_P_IDLE = 2'h0, NFC_P_SET = 2'h1, NFC_P_LOW = 2'h3,
		NFC_P_HIGH = 2'h2
	} nfc_ph_e;

endpackage : nfc_pkg

// *** sim/nfc_dev_model.sv ***
/* Behavioural model of the 8-bit flash device behind the host.
   Assumes the bench resolves the bus; drives ready high and low itself. */
`timescale 1ns/1ps

module nfc_dev_model #(
	parameter int T_BUSY = 400,
	parameter logic [7:0] ID0 = 8'h3c, // Arbitrary value
	parameter logic [7:0] ID1 = 8'hc5 // Arbitrary value
) (
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic io_oe,
	output logic rb_n
);
	logic [7:0] mem [int];
	logic [7:0] pbuf [528];
	logic [7:0] cmd;
	logic [23:0] ra;
	logic [17:0] ers [$];
	int col, base, acnt, idn, mode, a;

	function automatic int k(input int i);
		return int'(ra[17:0]) * 1024 + i;
	endfunction : k

	function automatic logic [7:0] rdm(input int i);
		return mem.exists(i) ? mem[i] : 8'hff;
	endfunction : rdm

	task automatic go_busy();
		rb_n = 1'b0;
		#(T_BUSY) rb_n = 1'b1;
	endtask : go_busy

	initial begin
		rb_n = 1'b1;
		io_oe = 1'b0;
		io_out = 8'h00;
		cmd = 8'h00;
		ra = 24'h0;
		base = 0;
		col = 0;
	end

	// ====================
	// Latching on the write strobe
	always @(posedge we_n) if (!ce_n) begin
		if (cle) begin
			if (rb_n || io_in inside {8'hff, 8'h70, 8'h71}) begin
				cmd = io_in;
				acnt = 0;
				idn = 0;
				mode = 0;
				case (io_in)
					8'h01: base = 256;
					8'h50: base = 512;
					8'h90: mode = 2;
					8'h70, 8'h71: mode = 1;
					8'h80: begin
						base = 0;
						pbuf = '{default: 8'hff};
					end
					8'h10, 8'h11: begin
						if (wp_n) for (int i = 0; i < 528; i++)
							mem[k(i)] = rdm(k(i)) & pbuf[i];
						fork go_busy(); join_none
					end
					8'hd0: begin
						foreach (ers[j]) if (wp_n) for (int i = 0; i < 32768; i++)
							mem.delete(int'({ers[j][17:5], 5'h0}) * 1024 + i);
						ers.delete();
						fork go_busy(); join_none
					end
					8'hff: fork go_busy(); join_none
					default: base = 0;
				endcase
			end
		end else if (ale) begin
			a = (cmd == 8'h60) ? acnt : acnt - 1;
			if (a < 0) col = base + int'(io_in);
			else if (a < 3) ra[a*8 +: 8] = io_in;
			if (a == 2 && cmd == 8'h60) ers.push_back(ra[17:0]);
			if (a == 2 && cmd inside {8'h00, 8'h01, 8'h50, 8'h03}) begin
				for (int i = 0; i < 528; i++) pbuf[i] = rdm(k(i));
				fork go_busy(); join_none
			end
			acnt++;
		end else begin
			pbuf[col % 528] = io_in;
			col++;
		end
	end

	// ====================
	// Read strobe and release
	always @(negedge re_n) if (!ce_n) begin
		io_oe = 1'b1;
		if (mode == 1) io_out = {wp_n, rb_n, 6'h00};
		else if (mode == 2) io_out = idn ? ID1 : ID0;
		else io_out = pbuf[col % 528];
		idn++;
		col++;
	end

	always @(posedge re_n or posedge ce_n) begin
		io_oe = 1'b0;
		if (ce_n && cmd == 8'h01) base = 0;
	end
endmodule : nfc_dev_model

// *** sim/nfc_host_props.sv ***
/* Pin and handshake checker for nfc_host.
   Bound to nfc_host; sees its ports only. */
`timescale 1ns/1ps

module nfc_host_props (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cmd_ready,
	input wire nfc_pkg::nfc_op_e cmd_op,
	input wire logic op_refused,
	input wire logic dev_busy,
	input wire logic allow_write,
	input wire logic protect_n,
	input wire logic nand_ce_n,
	input wire logic nand_cle,
	input wire logic nand_ale,
	input wire logic nand_we_n,
	input wire logic nand_re_n,
	input wire logic [7:0] shared_byte_bus_out,
	input wire logic shared_byte_bus_drive_n,
	input wire logic ready_busy_n
);
	import nfc_pkg::*;
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	// ====================
	// Assertions
	chk_latch_excl:
		assert property (!(nand_cle && nand_ale))
		else $error("both latch selects high");
	chk_we_select:
		assert property (!nand_we_n |-> !nand_ce_n && !shared_byte_bus_drive_n)
		else $error("write strobe without select or drive");
	chk_we_width:
		assert property ($fell(nand_we_n) |-> (!nand_we_n)[*4] ##1 nand_we_n)
		else $error("write strobe width wrong");
	chk_we_hold:
		assert property (!nand_we_n |-> $stable(shared_byte_bus_out)
			&& $stable(nand_cle) && $stable(nand_ale))
		else $error("bus or latch moved in write strobe");
	chk_read_release:
		assert property (!nand_re_n |-> nand_we_n && shared_byte_bus_drive_n)
		else $error("bus driven during read strobe");
	chk_re_width:
		assert property ($fell(nand_re_n) |-> (!nand_re_n)[*6] ##1 nand_re_n)
		else $error("read strobe width wrong");
	chk_idle_quiet:
		assert property (nand_ce_n |-> nand_we_n && nand_re_n)
		else $error("strobe while deselected");
	chk_busy_filter:
		assert property (cmd_ready && dev_busy |-> cmd_op inside
			{NFC_OP_RESET, NFC_OP_STATUS, NFC_OP_STATUS_MULTI})
		else $error("busy op accepted");
	chk_busy_track:
		assert property (!ready_busy_n ##1 !ready_busy_n |=> dev_busy)
		else $error("busy not seen");
	chk_protect_follow:
		assert property (!allow_write |=> !protect_n)
		else $error("protect not applied");

	cover property (op_refused);
	cover property ($fell(nand_re_n));
	cover property (cmd_ready && dev_busy);
endmodule : nfc_host_props

// *** sim/testbench.sv ***
/* Self-checking bench for nfc_host with a device model.
   Assumes design, package, header and checker compile first. */
`timescale 1ns/1ps

module testbench;
	import nfc_pkg::*;
	localparam logic [7:0] ID0 = 8'h3c; // Arbitrary value
	localparam logic [7:0] ID1 = 8'hc5; // Arbitrary value
	localparam logic [17:0] RA = 18'h00101;
	localparam logic [17:0] RB = 18'h00122;
	localparam logic [17:0] RC = 18'h00080;
	localparam logic [17:0] RD = 18'h00041;
	logic clk_sys, rstn, cmd_valid, cmd_ready, wr_valid, wr_ready, took;
	logic rd_valid, op_done, op_refused, dev_busy, allow_write, protect_n;
	logic nand_ce_n, nand_cle, nand_ale, nand_we_n, nand_re_n, drv_n;
	logic m_oe, rb_n;
	nfc_op_e cmd_op;
	logic [7:0] cmd_col, wr_data, rd_data, bus_out, m_out, idle_pat, e;
	logic [17:0] cmd_row, cmd_row2;
	logic [9:0] cmd_len;
	logic [31:0] rnd;
	logic [7:0] pat [4];
	logic [7:0] exp_q [$];
	logic [7:0] wq [$];
	int failures, checks_done;
	wire logic [7:0] bus_w = !drv_n ? bus_out : (m_oe ? m_out : idle_pat);

	nfc_host i_nfc_host (
		.clk_sys, .rstn, .cmd_valid, .cmd_ready, .cmd_op, .cmd_col,
		.cmd_row, .cmd_row2, .cmd_len, .wr_valid, .wr_ready, .wr_data,
		.rd_valid, .rd_data, .op_done, .op_refused, .dev_busy,
		.allow_write, .nand_ce_n, .nand_cle, .nand_ale, .nand_we_n,
		.nand_re_n, .protect_n, .shared_byte_bus_out(bus_out),
		.shared_byte_bus_in(bus_w), .shared_byte_bus_drive_n(drv_n),
		.ready_busy_n(rb_n)
	);
	nfc_dev_model #(.ID0(ID0), .ID1(ID1)) i_nfc_dev_model (
		.ce_n(nand_ce_n), .cle(nand_cle), .ale(nand_ale), .we_n(nand_we_n),
		.re_n(nand_re_n), .wp_n(protect_n), .io_in(bus_w), .io_out(m_out),
		.io_oe(m_oe), .rb_n
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	task automatic do_op(input nfc_op_e op, input logic [17:0] r,
		input int n, input logic refuse);
		int i;
		@(negedge clk_sys);
		cmd_op = op;
		cmd_row = r;
		cmd_len = 10'(n);
		cmd_valid = 1'b1;
		for (i = 0; i < 400; i++) begin
			@(posedge clk_sys);
			if (cmd_ready === 1'b1) break;
		end
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		while (op_done !== 1'b1 && op_refused !== 1'b1 && i < 5000) begin
			@(negedge clk_sys);
			i++;
		end
		if (i >= 5000) begin
			failures++;
			$display("unexpected at %0t: no answer", $time);
			complete_run();
		end else check(op_refused, refuse);
	endtask : do_op

	task automatic rd(input nfc_op_e op, input logic [17:0] r, input logic b);
		for (int i = 0; i < 4; i++) exp_q.push_back(b ? 8'hff : pat[i]);
		do_op(op, r, 4, 1'b0);
	endtask : rd

	task automatic wr(input nfc_op_e op, input logic [17:0] r);
		for (int i = 0; i < 4; i++) wq.push_back(pat[i]);
		do_op(op, r, 4, 1'b0);
	endtask : wr

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) idle_pat <= idle_pat + 8'h35;

	// ====================
	// Write data feeder and read monitor
	always @(negedge clk_sys) begin
		if (took) void'(wq.pop_front());
		took = wr_ready === 1'b1;
		wr_valid = wq.size() > 0;
		wr_data = wq.size() > 0 ? wq[0] : 8'h00;
	end

	always @(negedge clk_sys) begin
		if (rd_valid === 1'b1) begin
			e = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
			check(rd_data, e);
		end
	end

	// ====================
	// Main sequence
	initial begin
		rstn = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = NFC_OP_STATUS;
		cmd_row = 18'h0;
		cmd_row2 = 18'h0;
		cmd_len = 10'h0;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		allow_write = 1'b1;
		idle_pat = 8'h00;
		took = 1'b0;
		rnd = 32'hf59e;
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			pat[i] = rnd[7:0];
		end
		cmd_col = {2'b00, rnd[13:8]};
		repeat (4) @(negedge clk_sys);
		check(drv_n, 1'b1);
		check(protect_n, 1'b0);
		rstn = 1'b1;
		exp_q.push_back(8'hc0);
		do_op(NFC_OP_STATUS, RA, 1, 1'b0);
		exp_q.push_back(8'hc0);
		do_op(NFC_OP_STATUS_MULTI, RA, 1, 1'b0);
		exp_q.push_back(ID0);
		exp_q.push_back(ID1);
		do_op(NFC_OP_READ_ID, RA, 2, 1'b0);
		do_op(NFC_OP_RESET, RA, 1, 1'b0);
		$display("test status and id done");
		wr(NFC_OP_PROG, RA);
		rd(NFC_OP_READ_LO, RA, 1'b0);
		rd(NFC_OP_READ_HI, RA, 1'b1);
		rd(NFC_OP_READ_SPARE, RA, 1'b1);
		$display("test program and read done");
		cmd_row2 = RD;
		do_op(NFC_OP_COPY_DUMMY, RA, 1, 1'b0);
		cmd_row2 = RB;
		do_op(NFC_OP_COPY, RA, 1, 1'b0);
		rd(NFC_OP_READ_LO, RD, 1'b0);
		rd(NFC_OP_READ_LO, RB, 1'b0);
		$display("test copy done");
		do_op(NFC_OP_ERASE_ADD, RA, 1, 1'b0);
		do_op(NFC_OP_ERASE, RC, 1, 1'b1);
		do_op(NFC_OP_ERASE, RB, 1, 1'b0);
		rd(NFC_OP_READ_LO, RA, 1'b1);
		rd(NFC_OP_READ_LO, RB, 1'b1);
		rd(NFC_OP_READ_LO, RD, 1'b0);
		$display("test erase done");
		allow_write = 1'b0;
		exp_q.push_back(8'h40);
		do_op(NFC_OP_STATUS, RA, 1, 1'b0);
		wr(NFC_OP_PROG_DUMMY, RA);
		wr(NFC_OP_PROG, RB);
		rd(NFC_OP_READ_LO, RA, 1'b1);
		allow_write = 1'b1;
		check(8'(exp_q.size()), 8'h00);
		$display("test protect done");
		complete_run();
	end
endmodule : testbench

bind nfc_host nfc_host_props i_nfc_host_props (
	.clk_sys, .rstn, .cmd_ready, .cmd_op, .op_refused, .dev_busy,
	.allow_write, .protect_n, .nand_ce_n, .nand_cle, .nand_ale,
	.nand_we_n, .nand_re_n, .shared_byte_bus_out,
	.shared_byte_bus_drive_n, .ready_busy_n
);

// *** verilog/nfc_host.sv ***
/*
 * Host controller for an 8-bit multiplexed flash: turns user operations
 * into opcode, address and data cycles and waits on ready/busy.
 * Assumes a tristate pad outside joins bus out, in and drive enable, and
 * a pull-up on ready_busy_n.
 */
`timescale 1ns/1ps
`include "nfc_consts.svh"

module nfc_host (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire nfc_pkg::nfc_op_e cmd_op,
	input wire logic [7:0] cmd_col,
	input wire logic [17:0] cmd_row,
	input wire logic [17:0] cmd_row2,
	input wire logic [9:0] cmd_len,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [7:0] wr_data,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic op_done,
	output logic op_refused,
	output logic dev_busy,
	input wire logic allow_write,
	output logic nand_ce_n,
	output logic nand_cle,
	output logic nand_ale,
	output logic nand_we_n,
	output logic nand_re_n,
	output logic protect_n,
	output logic [7:0] shared_byte_bus_out,
	input wire logic [7:0] shared_byte_bus_in,
	output logic shared_byte_bus_drive_n,
	input wire logic ready_busy_n
);
	import nfc_pkg::*;

	localparam logic [7:0] WB_CYC = 8'(`NFC_NS2CYC(`NFC_T_WB_NS));

	typedef struct packed {
		nfc_st_e st;
		nfc_op_e op;
		logic [7:0] col;
		logic [17:0] row;
		logic [17:0] row2;
		logic [9:0] len;
		logic [9:0] cnt;
		logic [1:0] acnt;
		logic stage;
		logic [7:0] tmr;
		logic ce_n, multi, grp, rd_valid, done, err, wp_n;
		logic [7:0] rd_data;
	} nfc_host_s;

	nfc_host_s s_q, s_d;
	nfc_cyc_if cyc ();
	logic [8:0] pin_sync;
	logic rb_s;
	logic [7:0] bus_s;

	// ============================================================
	// Helpers
	function automatic logic [7:0] nfc_first_opc(input nfc_op_e op,
		input logic stage);
		logic [7:0] r;
		r = `NFC_OPC_STATUS;
		case (op)
			NFC_OP_READ_LO: r = `NFC_OPC_READ_LO;
			NFC_OP_READ_HI: r = `NFC_OPC_READ_HI;
			NFC_OP_READ_SPARE: r = `NFC_OPC_READ_SPARE;
			NFC_OP_READ_ID: r = `NFC_OPC_READ_ID;
			NFC_OP_RESET: r = `NFC_OPC_RESET;
			NFC_OP_PROG, NFC_OP_PROG_DUMMY: r = `NFC_OPC_PROG;
			NFC_OP_COPY: r = stage ? `NFC_OPC_COPY_DST
				: `NFC_OPC_READ_LO;
			NFC_OP_COPY_DUMMY: r = stage ? `NFC_OPC_COPY_DST
				: `NFC_OPC_COPY_SRC2;
			NFC_OP_ERASE, NFC_OP_ERASE_ADD: r = `NFC_OPC_ERASE;
			NFC_OP_STATUS_MULTI: r = `NFC_OPC_STATUS_MULTI;
			default: r = `NFC_OPC_STATUS;
		endcase
		return r;
	endfunction : nfc_first_opc

	function automatic logic nfc_is_erase(input nfc_op_e op);
		return op == NFC_OP_ERASE || op == NFC_OP_ERASE_ADD;
	endfunction : nfc_is_erase

	function automatic logic nfc_is_multi(input nfc_op_e op);
		return op == NFC_OP_PROG || op == NFC_OP_PROG_DUMMY ||
			op == NFC_OP_COPY || op == NFC_OP_COPY_DUMMY ||
			nfc_is_erase(op);
	endfunction : nfc_is_multi

	function automatic logic nfc_is_dummy(input nfc_op_e op);
		return op == NFC_OP_PROG_DUMMY || op == NFC_OP_COPY_DUMMY ||
			op == NFC_OP_ERASE_ADD;
	endfunction : nfc_is_dummy

	function automatic logic nfc_has_addr(input nfc_op_e op);
		return !(op == NFC_OP_READ_ID || op == NFC_OP_RESET ||
			op == NFC_OP_STATUS || op == NFC_OP_STATUS_MULTI);
	endfunction : nfc_has_addr

	function automatic logic [7:0] nfc_addr_byte(input logic [1:0] idx,
		input logic [7:0] col, input logic [17:0] row, input logic ers);
		logic [1:0] i;
		logic [7:0] r;
		// Erase skips the column byte
		i = ers ? 2'(idx + 2'd1) : idx;
		case (i)
			2'd0: r = col;
			2'd1: r = row[7:0];
			2'd2: r = row[15:8];
			default: r = {6'h00, row[17:16]};
		endcase
		return r;
	endfunction : nfc_addr_byte

	// ============================================================
	// Pin synchronisers and strobe engine
	nfc_sync #(.W(9)) u_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.din({ready_busy_n, shared_byte_bus_in}),
		.dout(pin_sync)
	);
	assign rb_s = pin_sync[8];
	assign bus_s = pin_sync[7:0];

	nfc_strobe u_strobe (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.cyc(cyc),
		.bus_sync(bus_s),
		.cle(nand_cle),
		.ale(nand_ale),
		.we_n(nand_we_n),
		.re_n(nand_re_n),
		.bus_out(shared_byte_bus_out),
		.bus_drive_n(shared_byte_bus_drive_n)
	);

	// ============================================================
	// Sequencer
	logic [9:0] cnt_nx;
	logic last_byte;
	logic [1:0] alast;
	logic refuse;
	logic [7:0] conf_opc;

	always_comb begin
		s_d = s_q;
		s_d.rd_valid = 1'b0;
		s_d.done = 1'b0;
		s_d.err = 1'b0;
		s_d.wp_n = allow_write;
		cnt_nx = 10'(s_q.cnt + 10'd1);
		last_byte = (cnt_nx >= s_q.len);
		alast = nfc_is_erase(s_q.op) ? `NFC_ADDR_CYC_BLOCK
			: `NFC_ADDR_CYC_PAGE;
		refuse = s_q.multi && nfc_is_multi(cmd_op) &&
			(cmd_row[`NFC_GROUP_BIT] != s_q.grp);
		conf_opc = nfc_is_erase(s_q.op) ? `NFC_OPC_ERASE_CONF
			: (nfc_is_dummy(s_q.op) ? `NFC_OPC_CONF_DUMMY
			: `NFC_OPC_CONF_TRUE);
		cmd_ready = (s_q.st == NFC_S_IDLE) && (rb_s ||
			cmd_op == NFC_OP_RESET || cmd_op == NFC_OP_STATUS ||
			cmd_op == NFC_OP_STATUS_MULTI);
		cyc.req = 1'b0;
		cyc.kind = NFC_K_CMD;
		cyc.wbyte = 8'h00;
		wr_ready = 1'b0;
		if (s_q.st != NFC_S_WAITB) begin
			s_d.tmr = WB_CYC;
		end
		case (s_q.st)
			NFC_S_IDLE: begin
				if (cmd_valid && cmd_ready) begin
					if (refuse) begin
						s_d.err = 1'b1;
					end else begin
						s_d.st = NFC_S_CMD;
						s_d.op = cmd_op;
						s_d.col = cmd_col;
						s_d.row = cmd_row;
						s_d.row2 = cmd_row2;
						s_d.len = (cmd_op == NFC_OP_STATUS ||
							cmd_op == NFC_OP_STATUS_MULTI) ? 10'd1 : cmd_len;
						s_d.stage = 1'b0;
						s_d.ce_n = 1'b0;
					end
				end
			end
			NFC_S_CMD: begin
				cyc.req = 1'b1;
				cyc.kind = NFC_K_CMD;
				cyc.wbyte = nfc_first_opc(s_q.op, s_q.stage);
				s_d.acnt = 2'd0;
				s_d.cnt = 10'd0;
				if (cyc.done) begin
					if (nfc_has_addr(s_q.op)) begin
						s_d.st = NFC_S_ADDR;
					end else if (s_q.op == NFC_OP_RESET) begin
						s_d.st = NFC_S_WAITB;
					end else begin
						s_d.st = NFC_S_READ;
					end
				end
			end
			NFC_S_ADDR: begin
				cyc.req = 1'b1;
				cyc.kind = NFC_K_ADDR;
				cyc.wbyte = nfc_addr_byte(s_q.acnt, s_q.col,
					s_q.stage ? s_q.row2 : s_q.row, nfc_is_erase(s_q.op));
				if (cyc.done) begin
					s_d.acnt = 2'(s_q.acnt + 2'd1);
					if (s_q.acnt == alast) begin
						case (s_q.op)
							NFC_OP_PROG, NFC_OP_PROG_DUMMY: s_d.st = NFC_S_WDATA;
							NFC_OP_COPY, NFC_OP_COPY_DUMMY:
								s_d.st = s_q.stage ? NFC_S_CONF : NFC_S_WAITB;
							NFC_OP_ERASE_ADD: s_d.st = NFC_S_FIN;
							NFC_OP_ERASE: s_d.st = NFC_S_CONF;
							default: s_d.st = NFC_S_WAITB;
						endcase
					end
				end
			end
			NFC_S_WDATA: begin
				cyc.req = wr_valid;
				cyc.kind = NFC_K_WDATA;
				cyc.wbyte = wr_data;
				wr_ready = cyc.done;
				if (cyc.done) begin
					s_d.cnt = cnt_nx;
					if (last_byte) begin
						s_d.st = NFC_S_CONF;
					end
				end
			end
			NFC_S_CONF: begin
				cyc.req = 1'b1;
				cyc.kind = NFC_K_CMD;
				cyc.wbyte = conf_opc;
				if (cyc.done) begin
					s_d.st = NFC_S_WAITB;
				end
			end
			NFC_S_WAITB: begin
				// Give the device time to pull busy low before trusting it
				if (s_q.tmr != 8'd0) begin
					s_d.tmr = 8'(s_q.tmr - 8'd1);
				end else if (rb_s) begin
					if (nfc_is_multi(s_q.op) && !s_q.stage &&
						(s_q.op == NFC_OP_COPY || s_q.op == NFC_OP_COPY_DUMMY)) begin
						s_d.stage = 1'b1;
						s_d.st = NFC_S_CMD;
					end else if (s_q.op == NFC_OP_READ_LO ||
						s_q.op == NFC_OP_READ_HI ||
						s_q.op == NFC_OP_READ_SPARE) begin
						s_d.st = NFC_S_READ;
					end else begin
						s_d.st = NFC_S_FIN;
					end
				end
			end
			NFC_S_READ: begin
				cyc.req = 1'b1;
				cyc.kind = NFC_K_RDATA;
				if (cyc.done) begin
					s_d.rd_valid = 1'b1;
					s_d.rd_data = cyc.rbyte;
					s_d.cnt = cnt_nx;
					if (last_byte) begin
						s_d.st = NFC_S_FIN;
					end
				end
			end
			NFC_S_FIN: begin
				s_d.ce_n = 1'b1;
				s_d.done = 1'b1;
				s_d.st = NFC_S_IDLE;
				if (nfc_is_multi(s_q.op)) begin
					s_d.multi = nfc_is_dummy(s_q.op);
					s_d.grp = s_q.row[`NFC_GROUP_BIT];
				end
			end
			default: s_d.st = NFC_S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{st: NFC_S_IDLE, op: NFC_OP_STATUS, col: 8'h00,
				row: 18'h00000, row2: 18'h00000, len: 10'h000, cnt: 10'h000,
				acnt: 2'h0, stage: 1'b0, tmr: 8'h00, ce_n: 1'b1,
				multi: 1'b0, grp: 1'b0, rd_valid: 1'b0, done: 1'b0,
				err: 1'b0, wp_n: 1'b0, rd_data: 8'h00};
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_valid = s_q.rd_valid;
	assign rd_data = s_q.rd_data;
	assign op_done = s_q.done;
	assign op_refused = s_q.err;
	assign dev_busy = !rb_s;
	assign nand_ce_n = s_q.ce_n;
	assign protect_n = s_q.wp_n;
endmodule : nfc_host

// *** verilog/nfc_strobe.sv ***
/*
 * Strobe engine: runs one latch, write or read bus cycle per request.
 * Assumes bus_sync is the pin bus after two synchronising flops.
 */
`timescale 1ns/1ps
`include "nfc_consts.svh"

module nfc_strobe (
	input wire logic clk_sys,
	input wire logic rstn,
	nfc_cyc_if.eng cyc,
	input wire logic [7:0] bus_sync,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic re_n,
	output logic [7:0] bus_out,
	output logic bus_drive_n
);
	import nfc_pkg::*;

	localparam logic [4:0] WP_CYC = 5'(`NFC_NS2CYC(`NFC_T_WP_NS));
	localparam logic [4:0] WH_CYC = 5'(`NFC_NS2CYC(`NFC_T_WH_NS));
	localparam logic [4:0] RP_CYC =
		5'(`NFC_NS2CYC(`NFC_T_REA_NS) + `NFC_SYNC_LAT);
	localparam logic [4:0] RH_CYC = 5'(`NFC_NS2CYC(`NFC_T_REH_NS));

	typedef struct packed {
		nfc_ph_e ph;
		logic rd;
		logic [4:0] tmr;
		logic cle, ale, we_n, re_n, drive_n, done;
		logic [7:0] bus, rbyte;
	} nfc_eng_s;

	nfc_eng_s s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		case (s_q.ph)
			NFC_P_IDLE: begin
				// Ignore req while done stands: the sequencer moves on only
				// at the next edge, so req and wbyte still show the old cycle
				if (cyc.req && !s_q.done) begin
					s_d.ph = NFC_P_SET;
					s_d.rd = (cyc.kind == NFC_K_RDATA);
					s_d.cle = (cyc.kind == NFC_K_CMD);
					s_d.ale = (cyc.kind == NFC_K_ADDR);
					s_d.bus = cyc.wbyte;
					// Release the bus for reads, drive it otherwise
					s_d.drive_n = (cyc.kind == NFC_K_RDATA);
				end
			end
			NFC_P_SET: begin
				s_d.ph = NFC_P_LOW;
				s_d.tmr = s_q.rd ? RP_CYC : WP_CYC;
				// Write strobe stays high through reads
				s_d.we_n = s_q.rd;
				s_d.re_n = !s_q.rd;
			end
			NFC_P_LOW: begin
				s_d.tmr = 5'(s_q.tmr - 5'd1);
				if (s_q.tmr == 5'd1) begin
					s_d.ph = NFC_P_HIGH;
					s_d.tmr = s_q.rd ? RH_CYC : WH_CYC;
					s_d.we_n = 1'b1;
					s_d.re_n = 1'b1;
					if (s_q.rd) begin
						s_d.rbyte = bus_sync;
					end
				end
			end
			NFC_P_HIGH: begin
				s_d.tmr = 5'(s_q.tmr - 5'd1);
				if (s_q.tmr == 5'd1) begin
					s_d.ph = NFC_P_IDLE;
					s_d.cle = 1'b0;
					s_d.ale = 1'b0;
					s_d.drive_n = 1'b1;
					s_d.done = 1'b1;
				end
			end
			default: s_d.ph = NFC_P_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_q <= '{ph: NFC_P_IDLE, rd: 1'b0, tmr: 5'h00, cle: 1'b0,
				ale: 1'b0, we_n: 1'b1, re_n: 1'b1, drive_n: 1'b1,
				done: 1'b0, bus: 8'h00, rbyte: 8'h00};
		end else begin
			s_q <= s_d;
		end
	end

	assign cyc.done = s_q.done;
	assign cyc.rbyte = s_q.rbyte;
	assign cle = s_q.cle;
	assign ale = s_q.ale;
	assign we_n = s_q.we_n;
	assign re_n = s_q.re_n;
	assign bus_out = s_q.bus;
	assign bus_drive_n = s_q.drive_n;
endmodule : nfc_strobe

// *** verilog/nfc_sync.sv ***
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to clk_sys.
 */
`timescale 1ns/1ps

module nfc_sync #(
	parameter int W = 9
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} nfc_sync_s;

	nfc_sync_s s_q, s_d;

	always_comb begin
		s_d.meta = din;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.sync;
endmodule : nfc_sync
